// file: logic/smbus_block_memory.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_block_memory #(
    parameter logic [6:0] SLAVE_ADDR = smbus_mem_pkg::SLAVE_ADDR_DEF,
    parameter int PROG_WAIT = smbus_mem_pkg::PROG_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_scl_oe_n,
    output logic o_sda,
    output logic o_sda_oe_n,
    output logic o_prog_busy
);
    import smbus_mem_pkg::*;

    localparam int CW = $clog2(PROG_WAIT + 1);

    scl_bit_if link_bits();

    scl_bit_capture u_capture (
        .i_scl(i_scl),
        .i_sda(i_sda),
        .link(link_bits)
    );

    logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q, tog_m, tog_s, tog_q;
    logic start_c, stop_c, scl_fall, bit_ev, byte_done, ack_end, ack_ok;
    logic pec_check, wr_data, ram_we, ee_we, in_ram, in_ee, mack, stretch;
    link_state_t st;
    mode_t mode;
    logic [3:0] bitcnt;
    logic [7:0] shreg, rx_byte, tx_byte, txsh, next_tx, rd_byte, crc, ee_hi;
    logic [15:0] ptr;
    logic [5:0] wr_left, tx_left;
    logic rw, br_pend, cmd_next, need_param, pec_seen, pec_tx, ack_pend;
    logic [CW-1:0] prog_cnt;
    logic [7:0] ram [RAM_DEPTH];
    logic [7:0] eeprom [EE_DEPTH];

    // Pins and toggle are asynchronous here; idle bus level is high
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            {scl_m, scl_s, scl_q} <= 3'h7;
            {sda_m, sda_s, sda_q} <= 3'h7;
            {tog_m, tog_s, tog_q} <= 3'h0;
        end else if (i_ce) begin
            {scl_m, scl_s, scl_q} <= {i_scl, scl_m, scl_s};
            {sda_m, sda_s, sda_q} <= {i_sda, sda_m, sda_s};
            {tog_m, tog_s, tog_q} <= {link_bits.bit_tog, tog_m, tog_s};
        end
    end

    assign start_c = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_c = scl_s & scl_q & ~sda_q & sda_s;
    assign scl_fall = scl_q & ~scl_s;
    // Captured bit stays put until the next SCL rise, long after the toggle lands
    assign bit_ev = tog_s ^ tog_q;
    assign rx_byte = {shreg[6:0], link_bits.bit_val};
    assign byte_done = bit_ev && (st == ST_ADDR || st == ST_RX) && bitcnt == 4'h7;
    assign ack_end = st == ST_ACK && !o_prog_busy && (scl_fall || stretch);

    assign in_ram = ptr <= RAM_TOP;
    assign in_ee = ptr >= EE_BASE && ptr <= EE_TOP;
    assign rd_byte = in_ram ? ram[ptr[7:0]] : (in_ee ? eeprom[ptr[8:0]] : ERASED);
    assign pec_check = st == ST_RX && !cmd_next && !need_param && wr_left == 6'h00;
    assign wr_data = byte_done && st == ST_RX && !cmd_next && !need_param && wr_left != 6'h00;
    assign ram_we = wr_data && in_ram;
    assign ee_we = wr_data && in_ee && !o_prog_busy && eeprom[ptr[8:0]] == ERASED;
    assign next_tx = tx_left != 6'h00 ? rd_byte : (!pec_tx ? crc : ERASED);

    always_comb begin
        if (st == ST_ADDR) begin
            ack_ok = rx_byte[7:1] == SLAVE_ADDR;
        end else if (cmd_next) begin
            ack_ok = rx_byte == CMD_BLK_WR || rx_byte == CMD_BLK_RD
                || rx_byte == EE_HI_FIRST || rx_byte == EE_HI_LAST
                || {8'h00, rx_byte} <= RAM_TOP;
        end else if (need_param || wr_left != 6'h00) begin
            ack_ok = 1'b1;
        end else begin
            ack_ok = !pec_seen && rx_byte == crc;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            st <= ST_IDLE;
        end else if (i_ce) begin
            if (start_c) begin
                st <= ST_ADDR;
            end else if (stop_c) begin
                st <= ST_IDLE;
            end else begin
                unique case (st)
                    ST_ADDR, ST_RX: begin
                        if (scl_fall && bitcnt == BYTE_BITS) begin
                            st <= ack_pend ? ST_ACK : ST_IGN;
                        end
                    end
                    ST_ACK: begin
                        if (ack_end) begin
                            st <= rw ? ST_TX : ST_RX;
                        end
                    end
                    ST_TX: begin
                        if (scl_fall && bitcnt == BYTE_BITS) begin
                            st <= ST_MACK;
                        end
                    end
                    ST_MACK: begin
                        if (scl_fall) begin
                            st <= mack ? ST_IGN : ST_TX;
                        end
                    end
                    ST_IDLE, ST_IGN: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            mack <= 1'b1;
        end else if (i_ce) begin
            if (start_c) begin
                bitcnt <= 4'h0;
            end else if (bit_ev && (st == ST_ADDR || st == ST_RX)) begin
                shreg <= rx_byte;
                bitcnt <= bitcnt + 4'h1;
            end else if (bit_ev && st == ST_MACK) begin
                mack <= link_bits.bit_val;
            end else if (ack_end) begin
                bitcnt <= rw ? 4'h1 : 4'h0;
            end else if (scl_fall && (st == ST_ADDR || st == ST_RX) && bitcnt == BYTE_BITS) begin
                bitcnt <= 4'h0;
            end else if (scl_fall && st == ST_TX) begin
                bitcnt <= bitcnt == BYTE_BITS ? 4'h0 : bitcnt + 4'h1;
            end else if (scl_fall && st == ST_MACK) begin
                bitcnt <= 4'h1;
            end
        end
    end

    // Data line: output enable low pulls SDA low
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_sda <= 1'b0;
            o_sda_oe_n <= 1'b1;
            txsh <= 8'h00;
        end else if (i_ce) begin
            if (start_c || stop_c) begin
                o_sda_oe_n <= 1'b1;
            end else if (scl_fall && (st == ST_ADDR || st == ST_RX) && bitcnt == BYTE_BITS) begin
                o_sda_oe_n <= ~ack_pend;
            end else if (ack_end) begin
                o_sda_oe_n <= rw ? tx_byte[7] : 1'b1;
                txsh <= {tx_byte[6:0], 1'b0};
            end else if (scl_fall && st == ST_TX) begin
                o_sda_oe_n <= bitcnt == BYTE_BITS ? 1'b1 : txsh[7];
                txsh <= {txsh[6:0], 1'b0};
            end else if (scl_fall && st == ST_MACK) begin
                o_sda_oe_n <= mack ? 1'b1 : next_tx[7];
                txsh <= {next_tx[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            mode <= MD_NONE;
            {rw, br_pend, cmd_next, need_param, pec_seen, pec_tx, ack_pend} <= 7'h00;
            ptr <= 16'h0000;
            ee_hi <= 8'h00;
            wr_left <= 6'h00;
            tx_left <= 6'h00;
            tx_byte <= 8'h00;
            crc <= CRC_INIT;
        end else if (i_ce) begin
            if (start_c) begin
                {cmd_next, need_param, pec_seen, pec_tx} <= 4'h0;
                wr_left <= 6'h00;
                if (st == ST_IDLE) begin
                    crc <= CRC_INIT;
                    br_pend <= 1'b0;
                end
            end else if (stop_c) begin
                br_pend <= 1'b0;
                mode <= MD_NONE;
            end else if (byte_done) begin
                ack_pend <= ack_ok;
                if (!pec_check) begin
                    crc <= crc8_step(crc, rx_byte);
                end
                if (st == ST_ADDR) begin
                    rw <= rx_byte[0];
                    cmd_next <= !rx_byte[0];
                    if (rx_byte[0] && br_pend) begin
                        tx_byte <= BLK_COUNT;
                        tx_left <= BLK_LEN;
                        mode <= MD_BLK_RD;
                    end else if (rx_byte[0]) begin
                        tx_byte <= rd_byte;
                        tx_left <= 6'h00;
                    end
                end else if (cmd_next) begin
                    cmd_next <= 1'b0;
                    br_pend <= rx_byte == CMD_BLK_RD;
                    if (rx_byte == CMD_BLK_WR) begin
                        mode <= MD_BLK_WR;
                        need_param <= 1'b1;
                    end else if (rx_byte == EE_HI_FIRST || rx_byte == EE_HI_LAST) begin
                        mode <= MD_EE_SET;
                        ee_hi <= rx_byte;
                        need_param <= 1'b1;
                    end else if ({8'h00, rx_byte} <= RAM_TOP) begin
                        ptr <= {8'h00, rx_byte};
                        wr_left <= 6'h01;
                    end
                end else if (need_param) begin
                    need_param <= 1'b0;
                    if (mode == MD_BLK_WR) begin
                        // Oversized counts are clipped to the block limit
                        wr_left <= rx_byte > BLK_COUNT ? BLK_LEN : rx_byte[5:0];
                    end else begin
                        ptr <= {ee_hi, rx_byte};
                        wr_left <= 6'h01;
                    end
                end else if (wr_left != 6'h00) begin
                    wr_left <= wr_left - 6'h01;
                    if (mode == MD_BLK_WR) begin
                        ptr <= ptr + 16'h0001;
                    end
                end else begin
                    pec_seen <= 1'b1;
                end
            end else if (scl_fall && st == ST_TX && bitcnt == BYTE_BITS && !pec_tx) begin
                crc <= crc8_step(crc, tx_byte);
            end else if (scl_fall && st == ST_MACK && !mack) begin
                tx_byte <= next_tx;
                if (tx_left != 6'h00) begin
                    tx_left <= tx_left - 6'h01;
                    ptr <= ptr + 16'h0001;
                end else begin
                    pec_tx <= 1'b1;
                end
            end
        end
    end

    // Arrays carry no reset: EEPROM is nonvolatile and starts erased
    initial begin
        for (int i = 0; i < EE_DEPTH; i++) begin
            eeprom[i] = ERASED;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_ce && ram_we) begin
            ram[ptr[7:0]] <= rx_byte;
        end
        if (i_ce && ee_we) begin
            eeprom[ptr[8:0]] <= rx_byte;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            prog_cnt <= '0;
            o_prog_busy <= 1'b0;
        end else if (i_ce) begin
            if (ee_we) begin
                prog_cnt <= CW'(PROG_WAIT);
                o_prog_busy <= 1'b1;
            end else if (prog_cnt != '0) begin
                prog_cnt <= prog_cnt - CW'(1);
                o_prog_busy <= prog_cnt != CW'(1);
            end
        end
    end

    // Hold SCL low after an acknowledge until programming is done
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_scl <= 1'b0;
            o_scl_oe_n <= 1'b1;
            stretch <= 1'b0;
        end else if (i_ce) begin
            if (st == ST_ACK && scl_fall && o_prog_busy) begin
                stretch <= 1'b1;
                o_scl_oe_n <= 1'b0;
            end else if (stretch && st != ST_ACK) begin
                // SCL lets go one cycle after SDA, so the next bit is set up first
                stretch <= 1'b0;
                o_scl_oe_n <= 1'b1;
            end
        end
    end

    a_blkwr_cmd_ack: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_ce && byte_done && cmd_next && rx_byte == CMD_BLK_WR |=> ack_pend && mode == MD_BLK_WR)
        else $error("block write command not acknowledged");

    a_blkwr_data_ack: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_ce && wr_data && mode == MD_BLK_WR |=> ack_pend)
        else $error("block write data byte not acknowledged");

    a_stretch_hold: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_ce && st == ST_ACK && scl_fall && o_prog_busy |=> !o_scl_oe_n ##1 !o_scl_oe_n)
        else $error("clock not stretched while programming");

    a_rd_addr_ack: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_ce && byte_done && st == ST_ADDR && rx_byte == {SLAVE_ADDR, 1'b1} && !br_pend
        |=> ack_pend && tx_byte == $past(rd_byte))
        else $error("receive byte address or data wrong");

    a_blkrd_cmd_ack: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_ce && byte_done && cmd_next && rx_byte == CMD_BLK_RD |=> ack_pend && br_pend)
        else $error("block read command not acknowledged");

    a_blkrd_count: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_ce && byte_done && st == ST_ADDR && rx_byte[0] && br_pend
        |=> tx_byte == BLK_COUNT && tx_left == 6'h20)
        else $error("block read count not 32");

    a_pec_check: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_ce && byte_done && pec_check && rx_byte != crc |=> !ack_pend)
        else $error("bad check byte acknowledged");

    a_crc_poly: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_ce && scl_fall && st == ST_MACK && !mack && tx_left == 6'h00 && !pec_tx
        |=> tx_byte == $past(crc) && crc8_step(8'h00, 8'h01) == 8'h07)
        else $error("check byte differs from CRC-8");

    a_ee_range: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_ce && (ee_we || ram_we) |-> (ee_we ? ptr >= EE_BASE && ptr <= EE_TOP : ptr <= RAM_TOP))
        else $error("write outside memory map");

    a_ee_erased: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_ce && wr_data && in_ee && eeprom[ptr[8:0]] != ERASED |-> !ee_we)
        else $error("programmed location overwritten");

    a_ptr_advance: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_ce && wr_data && mode == MD_BLK_WR |=> ptr == $past(ptr) + 16'h0001)
        else $error("pointer did not advance");
endmodule
`default_nettype wire

// file: logic/smbus_mem_pkg.sv
package smbus_mem_pkg;
    localparam logic [6:0] SLAVE_ADDR_DEF = 7'h34;
    localparam logic [7:0] CMD_BLK_WR = 8'hFC;
    localparam logic [7:0] CMD_BLK_RD = 8'hFD;
    localparam logic [7:0] EE_HI_FIRST = 8'hF8;
    localparam logic [7:0] EE_HI_LAST = 8'hF9;
    localparam logic [15:0] RAM_TOP = 16'h00DF;
    localparam logic [15:0] EE_BASE = 16'hF800;
    localparam logic [15:0] EE_TOP = 16'hF9FF;
    localparam int RAM_DEPTH = 224;
    localparam int EE_DEPTH = 512;
    localparam logic [7:0] BLK_COUNT = 8'h20;
    localparam logic [5:0] BLK_LEN = 6'h20;
    localparam logic [7:0] ERASED = 8'hFF;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int SYS_CLK_HZ = 20000000;
    localparam int PROG_TIME_US = 250;
    // Divide first: the full product overflows a 32-bit int
    localparam int PROG_CYCLES = PROG_TIME_US * (SYS_CLK_HZ / 1000000);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b011,
        ST_RX = 3'b010,
        ST_TX = 3'b110,
        ST_MACK = 3'b111,
        ST_IGN = 3'b101
    } link_state_t;

    typedef enum logic [1:0] {
        MD_NONE,
        MD_BLK_WR,
        MD_BLK_RD,
        MD_EE_SET
    } mode_t;

    function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction
endpackage

// file: logic/scl_bit_if.sv
`timescale 1ns/1ps
`default_nettype none
interface scl_bit_if;
    logic bit_val;
    logic bit_tog;
    modport capture (output bit_val, output bit_tog);
    modport consume (input bit_val, input bit_tog);
endinterface
`default_nettype wire

// file: logic/scl_bit_capture.sv
`timescale 1ns/1ps
`default_nettype none
module scl_bit_capture (
    input wire logic i_scl,
    input wire logic i_sda,
    scl_bit_if.capture link
);
    // SCL stops between frames, so no reset can reach here; power-up value instead
    logic val = 1'b1;
    logic tog = 1'b0;

    always_ff @(posedge i_scl) begin
        val <= i_sda;
        tog <= ~tog;
    end

    assign link.bit_val = val;
    assign link.bit_tog = tog;
endmodule
`default_nettype wire

// file: sim/smbus_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_oe_n,
    output logic o_sda_oe_n
);
    // Phases span many 12 ns ticks: the device needs 400 ns per SCL phase
    localparam int PH = 40;
    logic hclk = 1'b0;
    time fall_t = 0;
    time max_low_ns = 0;
    always #6 hclk = ~hclk;
    initial begin
        o_scl_oe_n = 1'b1;
        o_sda_oe_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // Bounded wait, so a stuck stretch cannot hang the host
    task automatic scl_up();
        int w;
        logic was_low;
        w = 0;
        // Idle-high SCL after a STOP is no low phase
        was_low = i_scl !== 1'b1;
        o_scl_oe_n = 1'b1;
        while (i_scl !== 1'b1 && w < 5000) begin
            @(posedge hclk);
            w++;
        end
        if (was_low && $time - fall_t > max_low_ns) begin
            max_low_ns = $time - fall_t;
        end
    endtask
    task automatic scl_down();
        o_scl_oe_n = 1'b0;
        fall_t = $time;
    endtask
    // Serves both START and repeated START
    task automatic start();
        o_sda_oe_n = 1'b1;
        tick(PH);
        scl_up();
        tick(PH);
        o_sda_oe_n = 1'b0;
        tick(PH);
        scl_down();
    endtask
    task automatic stop();
        o_sda_oe_n = 1'b0;
        tick(PH);
        scl_up();
        tick(PH);
        o_sda_oe_n = 1'b1;
        tick(PH);
    endtask
    task automatic bit_io(input logic b, output logic r);
        o_sda_oe_n = b;
        tick(PH);
        scl_up();
        tick(PH / 2);
        r = i_sda;
        tick(PH / 2);
        scl_down();
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // Host acks count and data, nacks the last byte read
    task automatic rbyte(output logic [7:0] d, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(~ack, r);
    endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import smbus_mem_pkg::*;
    localparam int PW = 40;
    localparam logic [7:0] AW = {SLAVE_ADDR_DEF, 1'b0};
    localparam logic [7:0] AR = {SLAVE_ADDR_DEF, 1'b1};
    logic i_sys_clk = 1'b0;
    logic i_srst = 1'b1;
    logic d_scl, d_scl_oe_n, d_sda, d_sda_oe_n, prog_busy, h_scl_oe_n, h_sda_oe_n;
    logic busy_seen = 1'b0;
    logic ack;
    logic [7:0] crc, got, e;
    int n_mismatch = 0;
    int comparisons = 0;
    wire scl;
    wire sda;
    // Open-drain wires with pull-ups
    assign scl = (h_scl_oe_n ? 1'b1 : 1'b0) & (d_scl_oe_n ? 1'b1 : d_scl);
    assign sda = (h_sda_oe_n ? 1'b1 : 1'b0) & (d_sda_oe_n ? 1'b1 : d_sda);
    always #25 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        if (prog_busy === 1'b1) begin
            busy_seen <= 1'b1;
        end
    end
    smbus_block_memory #(.PROG_WAIT(PW)) dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
        .i_ce(1'b1), .i_scl(scl), .i_sda(sda), .o_scl(d_scl), .o_scl_oe_n(d_scl_oe_n),
        .o_sda(d_sda), .o_sda_oe_n(d_sda_oe_n), .o_prog_busy(prog_busy));
    smbus_host_model host (.i_scl(scl), .i_sda(sda), .o_scl_oe_n(h_scl_oe_n),
        .o_sda_oe_n(h_sda_oe_n));
    function automatic logic [7:0] crc_ref(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] x;
        x = c ^ d;
        for (int i = 0; i < 8; i++) begin
            x = x[7] ? ({x[6:0], 1'b0} ^ CRC_POLY) : {x[6:0], 1'b0};
        end
        return x;
    endfunction
    function automatic logic [7:0] pat(input int i);
        return 8'(i * 37 + 17);
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        comparisons++;
        if (g !== x) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
            n_mismatch++;
        end
    endtask
    task automatic tx(input logic [7:0] b, input logic x_ack);
        host.wbyte(b, ack);
        crc = crc_ref(crc, b);
        chk({7'h00, ack}, {7'h00, x_ack});
    endtask
    task automatic rx(output logic [7:0] d, input logic a);
        host.rbyte(d, a);
        crc = crc_ref(crc, d);
    endtask
    task automatic set_ptr(input logic [7:0] hi, input logic [7:0] lo, input logic ee);
        host.start();
        tx(AW, 1'b1);
        tx(hi, 1'b1);
        if (ee) begin
            tx(lo, 1'b1);
        end
        host.stop();
    endtask
    task automatic t_refuse();
        host.start();
        tx({7'h35, 1'b0}, 1'b0);
        host.stop();
        host.start();
        tx(AW, 1'b1);
        tx(8'hE0, 1'b0);
        host.stop();
        crc = CRC_INIT;
        host.start();
        tx(AW, 1'b1);
        tx(8'h10, 1'b1);
        tx(8'h5A, 1'b1);
        tx(~crc, 1'b0);
        host.stop();
        crc = CRC_INIT;
        host.start();
        tx(AW, 1'b1);
        tx(8'h11, 1'b1);
        tx(8'hA5, 1'b1);
        tx(crc, 1'b1);
        tx(8'h00, 1'b0);
        host.stop();
    endtask
    task automatic t_ram_blk_wr();
        set_ptr(8'h20, 8'h00, 1'b0);
        crc = CRC_INIT;
        host.start();
        tx(AW, 1'b1);
        tx(CMD_BLK_WR, 1'b1);
        tx(BLK_COUNT, 1'b1);
        for (int i = 0; i < 32; i++) begin
            tx(pat(i), 1'b1);
        end
        tx(crc, 1'b1);
        host.stop();
    endtask
    task automatic t_blk_rd();
        set_ptr(8'h20, 8'h00, 1'b0);
        crc = CRC_INIT;
        host.start();
        tx(AW, 1'b1);
        tx(CMD_BLK_RD, 1'b1);
        host.start();
        tx(AR, 1'b1);
        rx(got, 1'b1);
        chk(got, BLK_COUNT);
        for (int i = 0; i < 32; i++) begin
            rx(got, 1'b1);
            chk(got, pat(i));
        end
        e = crc;
        rx(got, 1'b0);
        chk(got, e);
        host.stop();
    endtask
    // Twice in a row: a receive byte must not move the pointer
    task automatic t_rx_byte(input logic [7:0] hi, input logic [7:0] lo, input logic ee,
        input logic [7:0] x);
        set_ptr(hi, lo, ee);
        for (int k = 0; k < 2; k++) begin
            host.start();
            tx(AR, 1'b1);
            rx(got, 1'b0);
            chk(got, x);
            host.stop();
        end
    endtask
    task automatic t_ee_wr();
        chk({7'h00, busy_seen}, 8'h00);
        // Fresh locations at the very top, still erased
        set_ptr(EE_HI_LAST, 8'hFE, 1'b1);
        host.max_low_ns = 0;
        host.start();
        tx(AW, 1'b1);
        tx(CMD_BLK_WR, 1'b1);
        tx(8'h02, 1'b1);
        tx(8'hC3, 1'b1);
        tx(8'h3C, 1'b1);
        host.stop();
        chk({7'h00, busy_seen}, 8'h01);
        // Longer than the host's own low phase, but ends with programming
        chk({7'h00, host.max_low_ns > 600 && host.max_low_ns < PW * 50}, 8'h01);
        host.start();
        tx(AW, 1'b1);
        tx(EE_HI_LAST, 1'b1);
        tx(8'hFE, 1'b1);
        tx(8'h00, 1'b1);
        host.stop();
    endtask
    task automatic final_report();
        $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge i_sys_clk);
        #1 i_srst = 1'b0;
        repeat (8) @(posedge i_sys_clk);
        t_refuse();
        t_ram_blk_wr();
        t_blk_rd();
        t_rx_byte(8'h22, 8'h00, 1'b0, pat(2));
        t_ee_wr();
        t_rx_byte(EE_HI_LAST, 8'hFE, 1'b1, 8'hC3);
        t_rx_byte(EE_HI_LAST, 8'hFF, 1'b1, 8'h3C);
        final_report();
    end
    // Whole sequence needs about 1.1 ms
    initial begin
        #4000000;
        n_mismatch++;
        final_report();
    end
endmodule
`default_nettype wire
